// ===== src/dams_top.sv
// Top level: row map registers, row decode and DRAM address output
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
module dams_top
  import dams_pkg::*;
#(
  parameter int NROW = ROWS  // Rows in the map, at most eight
) (
  input  wire logic              ref_clk_in,           // 20 MHz clock
  input  wire logic              reset_n_in,           // Sync reset, low
  input  wire logic [ADR_W-1:0]  avs_address_in,       // Byte address
  input  wire logic              avs_read_in,          // Read request
  input  wire logic              avs_write_in,         // Write request
  input  wire logic [DAT_W-1:0]  avs_writedata_in,     // Write data
  input  wire logic [BE_W-1:0]   avs_byteenable_in,    // Byte lanes
  output logic [DAT_W-1:0]       avs_readdata_out,     // Read data
  output logic                   avs_waitrequest_out,  // Stall
  input  wire logic              host_cycle_in,        // Memory cycle
  input  wire logic [AW-1:0]     host_addr_in,         // Host address
  input  wire logic              col_phase_in,         // Column phase
  output logic [MW-1:0]          dram_mux_addr_out,    // DRAM address
  output logic                   mux_valid_out,        // Address valid
  output logic [2:0]             row_sel_out,          // Selected row
  output logic                   row_hit_out,          // Row was found
  output logic                   det_mode_out          // Detection on
);

  localparam int IDXW = $clog2(ROWS);  // Row index width

  //////////////////////////////////////////////////////////////////
  // Declarations
  //////////////////////////////////////////////////////////////////

  // Bus handshake states
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } dams_bus_e;

  dams_bus_e             bus_st;       // Bus state
  dams_bus_e             next_bus_st;  // Next bus state
  dams_cfg_s [NROW-1:0]  cfg_q;        // Row words
  logic                  det_en;       // Mapping detection enable
  logic                  stat_hit;     // Last cycle hit
  logic [IDXW-1:0]       stat_idx;     // Last row index
  logic                  stat_miss;    // Sticky miss flag
  logic                  next_miss;    // Next miss flag
  logic [DAT_W-1:0]      rd_data;      // Registered read data
  logic [DAT_W-1:0]      next_rd;      // Read data to capture
  logic                  bus_req;      // Read or write pending
  logic                  in_ack;       // Answer cycle
  logic                  wr_commit;    // Write takes effect
  logic                  aligned;      // Word aligned address
  logic                  sel_row;      // Row word addressed
  logic                  sel_ctrl;     // Control word addressed
  logic                  sel_stat;     // Status word addressed
  logic [IDXW-1:0]       row_widx;     // Row word index
  logic [DAT_W-1:0]      row_word;     // Row word, padded
  logic [DAT_W-1:0]      ctrl_word;    // Control word
  logic [DAT_W-1:0]      stat_word;    // Status word
  logic [DAT_W-1:0]      row_new;      // Row word after write
  logic [DAT_W-1:0]      ctrl_new;     // Control after write
  logic                  miss_set;     // Cycle found no row
  logic                  miss_clr;     // Software clears miss
  logic                  dec_hit;      // Decoder hit
  logic [IDXW-1:0]       dec_idx;      // Decoder row index
  logic [MW-1:0]         mux_q;        // Registered DRAM address
  logic                  mux_vld;      // Registered valid
  logic [IDXW-1:0]       row_sel_q;    // Registered row
  logic                  row_hit_q;    // Registered hit

  // Merges write data into a word by byte lane
  function automatic logic [DAT_W-1:0] be_merge(input logic [DAT_W-1:0] old,
                                                input logic [DAT_W-1:0] wd,
                                                input logic [BE_W-1:0] be);
    logic [DAT_W-1:0] r;
    r = old;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////
  // Avalon-MM slave
  //////////////////////////////////////////////////////////////////

  // Handshake: one wait cycle, then the answer
  assign bus_req             = avs_read_in | avs_write_in;
  assign in_ack              = (bus_st == BUS_ACK);
  assign avs_waitrequest_out = bus_req & ~in_ack;
  assign next_bus_st         = (bus_req && !in_ack) ? BUS_ACK : BUS_IDLE;
  assign wr_commit           = in_ack & avs_write_in;

  // Address decode
  assign aligned  = ((avs_address_in & ALIGN_MASK) == '0);
  assign sel_row  = aligned && (avs_address_in >= OFS_ROW0)
                    && (avs_address_in < OFS_CTRL);
  assign sel_ctrl = aligned && (avs_address_in == OFS_CTRL);
  assign sel_stat = aligned && (avs_address_in == OFS_STAT);
  assign row_widx = avs_address_in[WORD_LSB +: IDXW];

  // Readable words, unused bits read zero
  assign row_word  = {{(DAT_W-CFG_W){1'b0}}, cfg_q[row_widx]};
  assign ctrl_word = {{(DAT_W-1){1'b0}}, det_en};
  assign stat_word = {{(DAT_W-IDXW-2){1'b0}}, stat_miss, stat_idx, stat_hit};

  // Read selection, unmapped addresses read zero
  assign next_rd = sel_row  ? row_word  :
                   sel_ctrl ? ctrl_word :
                   sel_stat ? stat_word : '0;

  // Write merging; reserved row bits stay zero
  assign row_new  = be_merge(row_word, avs_writedata_in, avs_byteenable_in) & CFG_MASK;
  assign ctrl_new = be_merge(ctrl_word, avs_writedata_in, avs_byteenable_in);

  // Bus state register
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      bus_st <= BUS_IDLE;
    end else begin
      bus_st <= next_bus_st;
    end
  end

  // Read data captured as the answer cycle begins
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      rd_data <= '0;
    end else if (bus_req && !in_ack) begin
      rd_data <= next_rd;
    end
  end

  assign avs_readdata_out = rd_data;

  // Row words, programmed by software once sized
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      cfg_q <= {NROW{ROW_RST}};
    end else if (wr_commit && sel_row) begin
      cfg_q[row_widx] <= dams_cfg_s'(row_new[CFG_W-1:0]);
    end
  end

  // Detection enable
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      det_en <= 1'b0;
    end else if (wr_commit && sel_ctrl) begin
      det_en <= ctrl_new[CTRL_DET];
    end
  end

  assign det_mode_out = det_en;

  //////////////////////////////////////////////////////////////////
  // Row decode and address translation
  //////////////////////////////////////////////////////////////////

  dams_xlat_if xl_if ();  // Link to the translator

  // Finds the row of the current host cycle
  dams_rowdec #(
    .NROW (NROW),
    .IDXW (IDXW)
  ) u_rowdec (
    .cfg_in  (cfg_q),
    .addr_in (host_addr_in),
    .hit_out (dec_hit),
    .idx_out (dec_idx)
  );

  // Translator sees only the selected row's word
  assign xl_if.host_addr = host_addr_in;
  assign xl_if.col_phase = col_phase_in;
  assign xl_if.cfg       = cfg_q[dec_idx];
  assign xl_if.force_det = det_en;

  dams_mux u_mux (
    .x (xl_if)
  );

  // Output address and row, held between host cycles
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      mux_q     <= '0;
      mux_vld   <= 1'b0;
      row_sel_q <= '0;
      row_hit_q <= 1'b0;
    end else begin
      mux_vld <= host_cycle_in;
      if (host_cycle_in) begin
        mux_q     <= xl_if.mux_addr;
        row_sel_q <= dec_idx;
        row_hit_q <= dec_hit;
      end
    end
  end

  assign dram_mux_addr_out = mux_q;
  assign mux_valid_out     = mux_vld;
  assign row_sel_out       = row_sel_q;
  assign row_hit_out       = row_hit_q;

  //////////////////////////////////////////////////////////////////
  // Status
  //////////////////////////////////////////////////////////////////

  // Miss flag: a new miss wins over a clear
  assign miss_set  = host_cycle_in & ~dec_hit;
  assign miss_clr  = wr_commit & sel_stat & avs_byteenable_in[0]
                     & avs_writedata_in[STAT_MISS];
  assign next_miss = miss_set | (stat_miss & ~miss_clr);

  // Last cycle result and sticky miss
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      stat_hit  <= 1'b0;
      stat_idx  <= '0;
      stat_miss <= 1'b0;
    end else begin
      stat_miss <= next_miss;
      if (host_cycle_in) begin
        stat_hit <= dec_hit;
        stat_idx <= dec_idx;
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // Assertions
  //////////////////////////////////////////////////////////////////

  default clocking dams_cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  logic [AW-1:0] ha_d;    // Host address one cycle back
  logic          m64_d;   // 64-Mbit choice one cycle back
  logic          bk11_d;  // Bank bits on line 11 last cycle
  logic          cur_m64;  // 64-Mbit choice of this cycle

  assign cur_m64 = det_en || (xl_if.cfg.map == MAP_M64) || xl_if.cfg.m64;

  // Helper history for the address checks
  always_ff @(posedge ref_clk_in) begin
    ha_d   <= host_addr_in;
    m64_d  <= cur_m64;
    bk11_d <= !det_en && (xl_if.cfg.bank == BK_12_11);
  end

  a_std_row_map: assert property (
    host_cycle_in && !col_phase_in && !xl_if.asym_ok |=>
    dram_mux_addr_out[10:0] == {ha_d[23], ha_d[21], ha_d[20:12]})
    else $error("standard row address wrong");

  a_std_col_map: assert property (
    host_cycle_in && col_phase_in && !xl_if.asym_ok |=>
    dram_mux_addr_out[10:0] == {ha_d[24], ha_d[22], ha_d[11:3]}
    && (bk11_d || dram_mux_addr_out[11] == ha_d[26]))
    else $error("standard column address wrong");

  a_row_bit11: assert property (
    host_cycle_in && !col_phase_in && !xl_if.asym_ok |=>
    bk11_d || dram_mux_addr_out[11] == (m64_d ? ha_d[25] : ha_d[24]))
    else $error("row bit 11 ignores 64-Mbit choice");

  a_asym_row: assert property (
    host_cycle_in && !col_phase_in && xl_if.asym_ok |=>
    dram_mux_addr_out[10:0] == {ha_d[21], ha_d[11], ha_d[20:12]})
    else $error("asymmetric row address wrong");

  a_asym_col: assert property (
    host_cycle_in && col_phase_in && xl_if.asym_ok |=>
    dram_mux_addr_out[10:0] == ha_d[10:0])
    else $error("asymmetric column address wrong");

  a_asym_gate: assert property (
    xl_if.asym_ok |-> xl_if.cfg.rb == ROWB_12 && xl_if.cfg.map == MAP_ASYM
    && !det_en && (xl_if.cfg.cb == COLB_8 || xl_if.cfg.cb == COLB_9))
    else $error("asymmetric map on wrong organisation");

  a_det_bank: assert property (
    host_cycle_in && det_en |=>
    dram_mux_addr_out[13:12] == {ha_d[BK_HI], ha_d[BK_LO]})
    else $error("detection bank select wrong");

  a_row_select: assert property (
    host_cycle_in && dec_hit |=> row_hit_out && row_sel_out == $past(dec_idx)
    ##1 (mux_valid_out || row_sel_out == $past(row_sel_out)))
    else $error("row selection not held");

  a_size_range: assert property (
    host_cycle_in && dec_hit |-> cfg_q[dec_idx].size != SIZE_NONE)
    else $error("hit on an empty row");

  a_bus_answer: assert property (
    bus_req && !in_ack |=> !avs_waitrequest_out ##1 !in_ack)
    else $error("bus answer not after one wait");

  a_miss_sticky: assert property (
    miss_set |=> stat_miss)
    else $error("miss lost against clear");

  c_asym_cycle: cover property (host_cycle_in && xl_if.asym_ok ##1 mux_valid_out);
  c_m64_cycle:  cover property (host_cycle_in && cur_m64 && !col_phase_in);
  c_det_mode:   cover property (det_en && host_cycle_in);
  c_miss_clear: cover property (stat_miss ##1 miss_clr ##1 !stat_miss);

endmodule

// ===== src/dams_pkg.sv
// Shared constants, types and helpers for the DRAM address map block
package dams_pkg;

  // Sizes of buses and tables
  localparam int ROWS    = 8;   // DRAM rows held in the map
  localparam int AW      = 32;  // Host address width
  localparam int MW      = 14;  // Multiplexed DRAM address width
  localparam int DAT_W   = 32;  // Register data width
  localparam int BE_W    = 4;   // Register byte lanes
  localparam int ADR_W   = 6;   // Register byte address width
  localparam int CFG_W   = 14;  // Used bits of a row word
  localparam int MBW     = 11;  // Width of an address in 1MB units
  localparam int MB_LSB  = 20;  // Host bit of 1MB granularity
  localparam int WORD_LSB = 2;  // Byte address to word index

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_ROW0   = 6'h00;  // First row word
  localparam logic [ADR_W-1:0] OFS_CTRL   = 6'h20;  // Control word
  localparam logic [ADR_W-1:0] OFS_STAT   = 6'h24;  // Status word
  localparam logic [ADR_W-1:0] ALIGN_MASK = 6'h03;  // Low byte bits

  // Field positions and masks
  localparam logic [DAT_W-1:0] CFG_MASK = 32'h0000_3FF7;  // Writable row bits
  localparam int CTRL_DET  = 0;  // Mapping detection enable
  localparam int STAT_HIT  = 0;  // Last cycle hit a row
  localparam int STAT_IDX  = 1;  // Last row index, three bits
  localparam int STAT_MISS = 4;  // Sticky miss flag

  // Host bits that feed bank_pick
  localparam int BK_HI = 24;  // Upper bank select bit
  localparam int BK_LO = 23;  // Lower bank select bit

  // Organisation codes
  localparam logic [1:0] ROWB_12 = 2'h2;  // Twelve row bits
  localparam logic [1:0] COLB_8  = 2'h0;  // Eight column bits
  localparam logic [1:0] COLB_9  = 2'h1;  // Nine column bits
  localparam logic [2:0] SIZE_NONE = 3'h0;  // Empty row

  // Translation modes
  typedef enum logic [1:0] {
    MAP_STD  = 2'b00,
    MAP_M64  = 2'b01,
    MAP_ASYM = 2'b10
  } dams_map_e;

  // Bank select placements
  typedef enum logic [1:0] {
    BK_NONE  = 2'b00,
    BK_13    = 2'b01,
    BK_12_11 = 2'b10,
    BK_13_12 = 2'b11
  } dams_bank_e;

  // One row configuration word
  typedef struct packed {
    logic [1:0] cb;    // Column bits minus eight
    logic [1:0] rb;    // Row bits minus ten
    logic       w32;   // 32-bit populated row
    logic       m64;   // 64-Mbit parts present
    dams_bank_e bank;  // Bank select placement
    dams_map_e  map;   // Translation mode
    logic       rsv;   // Reserved, reads zero
    logic [2:0] size;  // Row size code
  } dams_cfg_s;

  localparam dams_cfg_s ROW_RST = '0;  // Row word after reset

  // Row size in MB: code 1 is 2MB up to code 7 at 128MB
  function automatic logic [MBW-1:0] size_mb(input logic [2:0] code);
    return (code == SIZE_NONE) ? '0 : (MBW'(1) << code);
  endfunction

endpackage

// ===== src/dams_xlat_if.sv
// Carrier between the top level and the address translator
`timescale 1ns/1ns
interface dams_xlat_if;
  import dams_pkg::*;
  logic [AW-1:0] host_addr;  // Host address of the cycle
  logic          col_phase;  // High in column phase
  dams_cfg_s     cfg;        // Config of the selected row
  logic          force_det;  // Mapping detection active
  logic [MW-1:0] mux_addr;   // Translated DRAM address
  logic          asym_ok;    // Asymmetric translation in use
  modport drv (output host_addr, col_phase, cfg, force_det, input mux_addr, asym_ok);
  modport xl (input host_addr, col_phase, cfg, force_det, output mux_addr, asym_ok);
endinterface

// ===== src/dams_rowdec.sv
// Row decoder: finds the DRAM row that holds a host address
`timescale 1ns/1ns
module dams_rowdec
  import dams_pkg::*;
#(
  parameter int NROW = ROWS,            // Rows in the map
  parameter int IDXW = $clog2(ROWS)     // Row index width
) (
  input  wire dams_cfg_s [NROW-1:0] cfg_in,   // All row words
  input  wire logic [AW-1:0]        addr_in,  // Host address
  output logic                      hit_out,  // Address in a row
  output logic [IDXW-1:0]           idx_out   // Row that holds it
);

  logic [MBW-1:0] mb_addr;  // Address in 1MB units
  assign mb_addr = addr_in[MB_LSB +: MBW];

  // Rows stack from row 0 upward, each at its own size
  always_comb begin
    logic [MBW:0] base;
    logic [MBW:0] top;
    base    = '0;
    top     = '0;
    hit_out = 1'b0;
    idx_out = '0;
    for (int i = 0; i < NROW; i++) begin
      top = base + {1'b0, size_mb(cfg_in[i].size)};
      if (!hit_out && !addr_in[AW-1] && ({1'b0, mb_addr} >= base)
          && ({1'b0, mb_addr} < top)) begin
        hit_out = 1'b1;
        idx_out = IDXW'(i);
      end
      base = top;
    end
  end

endmodule

// ===== src/dams_mux.sv
// Row and column address multiplexer for one DRAM row
`timescale 1ns/1ns
module dams_mux
  import dams_pkg::*;
(
  dams_xlat_if.xl x  // Address, phase and row config in
);

  logic [AW-1:0] ha;         // Host address
  logic          asym_org;   // Organisation allows asymmetric map
  logic          use_asym;   // Asymmetric map chosen
  logic          m64;        // 64-Mbit row bit choice
  dams_map_e     map_eff;    // Mode after detection override
  dams_bank_e    bank_eff;   // Bank placement after override
  logic [MW-1:0] std_row;    // Standard row phase
  logic [MW-1:0] std_col;    // Standard column phase
  logic [MW-1:0] asy_row;    // Asymmetric row phase
  logic [MW-1:0] asy_col;    // Asymmetric column phase
  logic [MW-1:0] base_addr;  // Address before bank bits

  // Places bank_pick bits onto the upper address lines
  function automatic logic [MW-1:0] bank_ovl(input logic [MW-1:0] a,
                                             input dams_bank_e b,
                                             input logic hi, input logic lo);
    logic [MW-1:0] r;
    r = a;
    case (b)
      BK_13: r[13] = lo;
      BK_13_12: begin
        r[13] = hi;
        r[12] = lo;
      end
      BK_12_11: begin
        r[12] = hi;
        r[11] = lo;
      end
      default: r = a;
    endcase
    return r;
  endfunction

  assign ha = x.host_addr;
  // Detection forces 64-Mbit map with bank select on 13:12
  assign map_eff  = x.force_det ? MAP_M64 : x.cfg.map;
  assign bank_eff = x.force_det ? BK_13_12 : x.cfg.bank;
  assign m64      = (map_eff == MAP_M64) || x.cfg.m64;
  // Asymmetric map only for 12 row bits with 8 or 9 columns
  assign asym_org = (x.cfg.rb == ROWB_12) && ((x.cfg.cb == COLB_8) || (x.cfg.cb == COLB_9));
  assign use_asym = (map_eff == MAP_ASYM) && asym_org;
  // Standard phases
  assign std_row = {2'b00, m64 ? ha[25] : ha[24], ha[23], ha[21], ha[20:12]};
  assign std_col = {2'b00, ha[26], ha[24], ha[22], ha[11:3]};
  // Asymmetric phases
  assign asy_row = {2'b00, ha[22], ha[21], ha[11], ha[20:12]};
  assign asy_col = {2'b00, ha[23], ha[10:0]};
  assign base_addr = use_asym ? (x.col_phase ? asy_col : asy_row)
                              : (x.col_phase ? std_col : std_row);
  assign x.mux_addr = bank_ovl(base_addr, bank_eff, ha[BK_HI], ha[BK_LO]);
  assign x.asym_ok  = use_asym;

endmodule

// ===== dv/dams_dram_model.sv
// DRAM row array model seen through the multiplexed address
`timescale 1ns/1ns
module dams_dram_model
  import dams_pkg::*;
(
  input  wire logic             clk_in,   // Host clock
  input  wire logic             valid_in, // Address strobe from the block
  input  wire logic             col_in,   // Column phase of the strobe
  input  wire logic [MW-1:0]    addr_in,  // Multiplexed address
  input  wire logic             we_in,    // Write on column strobe
  input  wire logic [DAT_W-1:0] wdata_in, // Write data
  output logic      [DAT_W-1:0] rdata_out // Read data
);
  logic [MW-1:0]    row_q;                  // Open row address
  logic [DAT_W-1:0] mem [logic [2*MW-1:0]]; // Written cells only
  initial rdata_out = '0;
  // Row strobe opens a row, column strobe moves data
  always @(posedge clk_in) begin
    if (valid_in && !col_in) begin
      row_q <= addr_in;
    end else if (valid_in && we_in) begin
      mem[{row_q, addr_in}] = wdata_in;
    end else if (valid_in) begin
      // Unwritten cells give a key pattern, never stale data
      rdata_out <= mem.exists({row_q, addr_in}) ? mem[{row_q, addr_in}] : ~{4'h0, row_q, addr_in};
    end
  end
endmodule

// ===== dv/dams_top_tb.sv
// Self-checking bench for the DRAM address map block
`timescale 1ns/1ns
module dams_top_tb;
  import dams_pkg::*;
  logic             ref_clk_in, reset_n_in, host_cycle_in, col_phase_in; // Clock, reset, host
  logic             avs_read_in, avs_write_in, mdl_we, det;  // Strobes, model write, det on
  logic [ADR_W-1:0] avs_address_in;                          // Register address
  logic [DAT_W-1:0] avs_writedata_in, avs_readdata_out, mdl_wd, mdl_rd, rd, q1, q2; // Data
  logic [DAT_W-1:0] d [3];                                   // Detection dwords
  logic [BE_W-1:0]  avs_byteenable_in;                       // Byte lanes
  logic             avs_waitrequest_out, mux_valid_out, row_hit_out, det_mode_out; // Status
  logic [AW-1:0]    host_addr_in, a;                         // Host address
  logic [MW-1:0]    dram_mux_addr_out;                       // DRAM address
  logic [2:0]       row_sel_out;                             // Selected row
  dams_cfg_s        cfg [2];                                 // Rows 0 and 1 as programmed
  int               n_errors, check_count, seed;             // Counters and seed
  dams_top i_dams_top (.ref_clk_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .host_cycle_in, .host_addr_in, .col_phase_in, .dram_mux_addr_out, .mux_valid_out,
    .row_sel_out, .row_hit_out, .det_mode_out);
  dams_dram_model i_dams_dram_model (.clk_in(ref_clk_in), .valid_in(mux_valid_out),
    .col_in(col_phase_in), .addr_in(dram_mux_addr_out), .we_in(mdl_we), .wdata_in(mdl_wd),
    .rdata_out(mdl_rd));
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 50 ns
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  // Expected multiplexed address for one phase
  function automatic logic [MW-1:0] emux(input logic [AW-1:0] a, input logic col,
                                         input dams_cfg_s c);
    logic [MW-1:0] m;
    logic          asym;
    logic [1:0]    bk;
    bk = det ? 2'h3 : c.bank;
    asym = !det && c.map == MAP_ASYM && c.rb == ROWB_12 && (c.cb == COLB_8 || c.cb == COLB_9);
    if (asym) m = col ? {2'h0, a[23], a[10:0]} : {2'h0, a[22], a[21], a[11], a[20:12]};
    else m = col ? {2'h0, a[26], a[24], a[22], a[11:3]}
                 : {2'h0, (det || c.map == MAP_M64 || c.m64) ? a[25] : a[24], a[23], a[21], a[20:12]};
    case (bk)
      2'h1: m[13] = a[BK_LO];
      2'h2: m[12:11] = {a[BK_HI], a[BK_LO]};
      2'h3: m[13:12] = {a[BK_HI], a[BK_LO]};
      default: ;
    endcase
    return m;
  endfunction
  // Bank pick placement concluded from the two detection reads
  function automatic logic [1:0] det_res();
    if (q1 == d[2] && q2 == d[0]) return BK_13;
    if (q1 == d[1] && q2 == d[1]) return BK_12_11;
    if (q1 == d[1] && q2 == d[0]) return BK_13_12;
    return BK_NONE;
  endfunction
  // Verdict and end of run
  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One register access, held until waitrequest is low
  task automatic bus(input logic w, input logic [ADR_W-1:0] ad, input logic [DAT_W-1:0] wd,
                     output logic [DAT_W-1:0] q);
    int n;
    n = 0;
    avs_address_in <= ad;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= wd;
    @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0 && n < 50) begin
      n++;
      @(posedge ref_clk_in);
    end
    if (n >= 50) begin
      n_errors++;
      end_of_test();
    end
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  // One host strobe, then check the address and row outputs
  task automatic hcyc(input logic [AW-1:0] ha, input logic col, input logic we,
                      input logic [DAT_W-1:0] wd, input logic eh, input logic [2:0] er);
    host_addr_in <= ha;
    col_phase_in <= col;
    host_cycle_in <= 1'b1;
    mdl_we <= we;
    mdl_wd <= wd;
    @(posedge ref_clk_in);
    host_cycle_in <= 1'b0;
    @(posedge ref_clk_in);
    chk(mux_valid_out, 1);
    chk(dram_mux_addr_out, emux(ha, col, cfg[er[0]]));
    chk(row_hit_out, eh);
    chk(row_sel_out, er);
  endtask
  // Row strobe then column strobe; read data taken one edge later
  task automatic rw(input logic [AW-1:0] ha, input logic we, input logic [DAT_W-1:0] wd,
                    output logic [DAT_W-1:0] q);
    hcyc(ha, 1'b0, 1'b0, 32'h0, 1'b1, 3'h0);
    hcyc(ha, 1'b1, we, wd, 1'b1, 3'h0);
    @(posedge ref_clk_in);
    q = mdl_rd;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {reset_n_in, host_cycle_in, col_phase_in, avs_read_in, avs_write_in, mdl_we, det} = '0;
    {avs_address_in, avs_writedata_in, host_addr_in, mdl_wd} = '0;
    avs_byteenable_in = 4'hF;
    {n_errors, check_count} = '0;
    seed = 32'h11E47266;
    cfg[0] = '0;
    cfg[1] = '0;
    repeat (10) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(posedge ref_clk_in);
    // Reset value, reserved bits, unmapped place
    bus(0, OFS_ROW0, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1, OFS_ROW0, 32'hFFFF_FFFF, rd);
    bus(0, OFS_ROW0, 32'h0, rd);
    chk(rd, CFG_MASK);
    bus(1, 6'h30, 32'hFFFF_FFFF, rd);
    bus(0, 6'h30, 32'h0, rd);
    chk(rd, 32'h0);
    $display("Test registers done");
    // Random row words, odd passes ask for the asymmetric map
    for (int k = 0; k < 24; k++) begin
      for (int r = 0; r < 2; r++) begin
        rd = $random(seed);
        cfg[r] = dams_cfg_s'(rd[CFG_W-1:0]);
        cfg[r].size = 3'h7;
        cfg[r].rsv = 1'b0;
        if (k % 2 == 1) cfg[r].map = MAP_ASYM;
        if (k % 4 == 1) cfg[r].rb = ROWB_12;
        bus(1, OFS_ROW0 + ADR_W'(4 * r), DAT_W'(cfg[r]), rd);
      end
      repeat (12) begin
        a = $random(seed) & 32'h0FFF_FFFF;
        hcyc(a, a[0] ^ a[30], 1'b0, 32'h0, 1'b1, {2'h0, a[27]});
      end
    end
    $display("Test mapping done");
    // Mapping detection sequence on a 128MB row
    cfg[0] = '0;
    cfg[1] = '0;
    cfg[0].size = 3'h7;
    cfg[0].m64 = 1'b1;
    cfg[0].map = MAP_M64;
    cfg[0].bank = BK_13_12;
    bus(1, OFS_ROW0, DAT_W'(cfg[0]), rd);
    bus(1, OFS_ROW0 + 6'h04, 32'h0, rd);
    bus(1, OFS_CTRL, 32'h1, rd);
    det = 1'b1;
    @(posedge ref_clk_in);
    chk(det_mode_out, 1);
    for (int i = 0; i < 3; i++) begin
      d[i] = $random(seed);
      a = 32'h0080_0000 * i;
      hcyc(a, 1'b0, 1'b0, 32'h0, 1'b1, 3'h0);
      hcyc(a, 1'b1, 1'b1, d[i], 1'b1, 3'h0);
    end
    for (int i = 0; i < 2; i++) begin
      a = (i == 0) ? 32'h0080_0000 : 32'h0;
      hcyc(a, 1'b0, 1'b0, 32'h0, 1'b1, 3'h0);
      hcyc(a, 1'b1, 1'b0, 32'h0, 1'b1, 3'h0);
      @(posedge ref_clk_in);
      if (i == 0) q1 = mdl_rd;
      else q2 = mdl_rd;
    end
    chk(q1, d[1]);
    chk(q2, d[0]);
    chk(det_res(), BK_13_12);
    bus(1, OFS_CTRL, 32'h0, rd);
    det = 1'b0;
    @(posedge ref_clk_in);
    chk(det_mode_out, 0);
    $display("Test detection done");
    // Autosizing walk from bit 26 down; a full 128MB row never aliases
    for (int b = 26; b >= 22; b--) begin
      d[0] = $random(seed);
      d[1] = ~d[0];
      rw(32'h1 << b, 1'b1, d[0], rd);
      rw(32'h0, 1'b1, d[1], rd);
      rw(32'h1 << b, 1'b0, 32'h0, rd);
      chk(rd, d[0]);
    end
    $display("Test autosizing done");
    // Smallest row: last eight-byte word hits, next megabyte misses
    cfg[0].size = 3'h1;
    bus(1, OFS_ROW0, DAT_W'(cfg[0]), rd);
    hcyc(32'h001F_FFF8, 1'b1, 1'b0, 32'h0, 1'b1, 3'h0);
    hcyc(32'h0020_0000, 1'b0, 1'b0, 32'h0, 1'b0, 3'h0);
    bus(0, OFS_STAT, 32'h0, rd);
    chk(rd[STAT_MISS], 1);
    bus(1, OFS_STAT, 32'h10, rd);
    bus(0, OFS_STAT, 32'h0, rd);
    chk(rd[STAT_MISS], 0);
    hcyc(32'h8000_0000, 1'b0, 1'b0, 32'h0, 1'b0, 3'h0);
    $display("Test sizing done");
    end_of_test();
  end
endmodule
